// *** core/flash_ctrl_defs.vh ***
`ifndef FLASH_CTRL_DEFS_VH
`define FLASH_CTRL_DEFS_VH
// Register offsets are printed as indices; byte address is four times the index
`define IDX_TIMING       8'hAB
`define IDX_ADDR_LOW     8'hAC
`define IDX_ADDR_HIGH    8'hAD
`define IDX_CONTROL      8'hAE
`define IDX_WDATA        8'hAF
`define IDX_IRQ_STATUS   8'hB0
`define IDX_IRQ_ENABLE   8'hB1
`define IDX_IRQ_CLEAR    8'hB2
`define IDX_POWER        8'hB3
// Field positions
`define CTL_BUSY         7
`define CTL_WBUSY        6
`define CTL_CONTINUOUS_READ_ENABLE       4
`define CTL_WRITE        1
`define CTL_ERASE        0
// Reset values
`define RST_TIMING       6'h11
`define RST_BYTE         8'h00
// Timing
`define WRITE_TIMEOUT_NS 40000
`define CLK_PERIOD_NS    25
// Interrupt bit positions
`define IRQ_ERASE_DONE   0
`define IRQ_WORD_DONE    1
`define IRQ_TIMEOUT      2
`endif

// *** core/flash_program_erase_control.v ***
`timescale 1ns/100ps
`include "flash_ctrl_defs.vh"
// Notes on behaviour
// - Software loads timing value matching clock; generator scales erase and program timing from it (pair timeout counts clocks).
// - Timing field resets to 0x11.
// - Control bit 7 reads 1 while program or erase is in progress.
// - Control bit 6 sets after two data bytes, stays set while word programs.
// - Control bit 4 selects continuous read enable, reset 0.
// - Writing 1 to control bit 1 starts programming; reads back 0.
// - Write and erase together: erase page first, then program.
// - Writing 1 to control bit 0 erases page high-address bits 5:1; reads 0.
// - Write and erase bits read 0 after deepest power modes.
// - Data register resets 0x00; each second byte launches one word program.
// - High address keeps 6-bit field reset zero; bits 7:6 unused.
// - Low address is 8-bit read/write, reset 0x00.
// - First byte of a pair is the low byte of the word.
// - Pair must come within 40 us, else abort, busy clears, address kept.
// - Completed erase leaves the whole page reading all ones.
// - Page holds 512 words, addressed by high bit 0 and low byte.
module flash_program_erase_control #(
   parameter ERASE_UNITS   = 16'd1000,
   parameter PROGRAM_UNITS = 16'd2,
   parameter TIMEOUT_CYC   = `WRITE_TIMEOUT_NS / `CLK_PERIOD_NS
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg  [13:0] flash_addr,
   output reg  [15:0] flash_wdata,
   output reg         flash_prog,
   output reg         flash_erase,
   output reg  [4:0]  flash_page,
   output wire        flash_read_hold,
   output reg         flash_tick,
   output wire        irq
);
   // ***********************************************************
   // States
   // ***********************************************************
   localparam ST_IDLE  = 4'b0001;
   localparam ST_ERASE = 4'b0010;
   localparam ST_WAIT  = 4'b0100;
   localparam ST_PROG  = 4'b1000;
   // The timeout count is held in 16 bits; wider settings are cut on purpose
   localparam [31:0] TOUT_FULL = TIMEOUT_CYC;
   localparam [15:0] TOUT      = TOUT_FULL[15:0];

   reg [3:0]  state_reg;
   reg [5:0]  timing_reg;
   reg [7:0]  addr_low_reg;
   reg [5:0]  addr_high_reg;
   reg        continuous_read_enable_reg;
   reg        write_reg;
   reg [7:0]  wdata_reg;
   reg        half_reg;
   reg [2:0]  irq_status_reg;
   reg [2:0]  irq_enable_reg;
   reg [5:0]  tick_cnt_reg;
   reg [15:0] op_cnt_reg;
   reg [15:0] tout_cnt_reg;
   reg        aw_reg;
   reg        w_reg;
   reg [31:0] awaddr_reg;
   reg [31:0] wdata_in_reg;
   reg [3:0]  wstrb_reg;
   reg [2:0]  irq_set;

   // ***********************************************************
   // AXI4-Lite slave
   // ***********************************************************
   assign s_axi_awready = !aw_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   wire       wr_go  = aw_reg && w_reg && !s_axi_bvalid;
   wire [7:0] wr_idx = awaddr_reg[9:2];
   wire       wr_hit = wr_go && wstrb_reg[0] && (awaddr_reg[31:10] == 22'h0);
   wire [7:0] wb     = wdata_in_reg[7:0];
   wire       wr_ctl = wr_hit && wr_idx == `IDX_CONTROL;
   wire       wr_dat = wr_hit && wr_idx == `IDX_WDATA;
   wire       busy   = (state_reg != ST_IDLE);
   wire       wbusy  = (state_reg == ST_PROG);
   wire       start_erase = wr_ctl && wb[`CTL_ERASE] && !busy;
   wire       start_write = wr_ctl && wb[`CTL_WRITE] && !busy;
   // Power-down return strobe: command bits must not survive it
   wire       pwr_wake = wr_hit && wr_idx == `IDX_POWER && wb[0];

   function valid_idx;
      input [7:0] idx;
      begin
         valid_idx = (idx >= `IDX_TIMING) && (idx <= `IDX_POWER);
      end
   endfunction

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_reg       <= 1'b0;
         w_reg        <= 1'b0;
         awaddr_reg   <= 32'h0;
         wdata_in_reg <= 32'h0;
         wstrb_reg    <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_reg     <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_reg        <= 1'b1;
            wdata_in_reg <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_reg       <= 1'b0;
            w_reg        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (valid_idx(wr_idx) && awaddr_reg[31:10] == 22'h0) ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   wire [7:0] rd_idx = s_axi_araddr[9:2];
   reg  [7:0] rd_byte;
   always @* begin
      case (rd_idx)
         `IDX_TIMING:     rd_byte = {2'b00, timing_reg};
         `IDX_ADDR_LOW:   rd_byte = addr_low_reg;
         `IDX_ADDR_HIGH:  rd_byte = {2'b00, addr_high_reg};
         `IDX_CONTROL:    rd_byte = {busy, wbusy, 1'b0, continuous_read_enable_reg, 4'b0000};
         `IDX_WDATA:      rd_byte = wdata_reg;
         `IDX_IRQ_STATUS: rd_byte = {5'b0, irq_status_reg};
         `IDX_IRQ_ENABLE: rd_byte = {5'b0, irq_enable_reg};
         default:         rd_byte = 8'h00;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h0, rd_byte};
         s_axi_rresp  <= (valid_idx(rd_idx) && s_axi_araddr[31:10] == 22'h0) ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ***********************************************************
   // Timing generator: one tick every timing_reg+1 clocks
   // ***********************************************************
   always @(posedge aclk) begin
      if (!aresetn || state_reg == ST_IDLE || state_reg == ST_WAIT) begin
         tick_cnt_reg <= 6'h0;
         flash_tick   <= 1'b0;
      end else if (tick_cnt_reg >= timing_reg) begin
         tick_cnt_reg <= 6'h0;
         flash_tick   <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 6'd1;
         flash_tick   <= 1'b0;
      end
   end

   assign flash_read_hold = continuous_read_enable_reg;

   // ***********************************************************
   // Registers and sequencer
   // ***********************************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_reg      <= ST_IDLE;
         timing_reg     <= `RST_TIMING;
         addr_low_reg   <= `RST_BYTE;
         addr_high_reg  <= 6'h0;
         continuous_read_enable_reg     <= 1'b0;
         write_reg      <= 1'b0;
         wdata_reg      <= `RST_BYTE;
         half_reg       <= 1'b0;
         irq_enable_reg <= 3'b000;
         op_cnt_reg     <= 16'h0;
         tout_cnt_reg   <= 16'h0;
         flash_addr     <= 14'h0;
         flash_wdata    <= 16'h0;
         flash_prog     <= 1'b0;
         flash_erase    <= 1'b0;
         flash_page     <= 5'h0;
      end else begin
         if (wr_hit && wr_idx == `IDX_TIMING)
            timing_reg <= wb[5:0];
         if (wr_hit && wr_idx == `IDX_ADDR_LOW && !busy)
            addr_low_reg <= wb;
         if (wr_hit && wr_idx == `IDX_ADDR_HIGH && !busy)
            addr_high_reg <= wb[5:0];
         if (wr_ctl)
            continuous_read_enable_reg <= wb[`CTL_CONTINUOUS_READ_ENABLE];
         if (wr_hit && wr_idx == `IDX_IRQ_ENABLE)
            irq_enable_reg <= wb[2:0];
         // Bytes arriving while a word programs are dropped; software must poll first
         if (wr_dat && !wbusy)
            wdata_reg <= wb;
         flash_prog  <= 1'b0;
         flash_erase <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               half_reg <= 1'b0;
               if (start_erase) begin
                  write_reg   <= wb[`CTL_WRITE];
                  flash_page  <= addr_high_reg[5:1];
                  flash_erase <= 1'b1;
                  op_cnt_reg  <= ERASE_UNITS;
                  state_reg   <= ST_ERASE;
               end else if (start_write) begin
                  write_reg    <= 1'b1;
                  tout_cnt_reg <= TOUT;
                  state_reg    <= ST_WAIT;
               end
            end
            ST_ERASE: begin
               if (flash_tick)
                  op_cnt_reg <= op_cnt_reg - 16'd1;
               if (flash_tick && op_cnt_reg <= 16'd1) begin
                  tout_cnt_reg <= TOUT;
                  state_reg    <= write_reg ? ST_WAIT : ST_IDLE;
               end
            end
            ST_WAIT: begin
               if (wr_dat) begin
                  half_reg <= !half_reg;
                  if (half_reg) begin
                     flash_wdata <= {wb, wdata_reg};
                     flash_addr  <= {addr_high_reg, addr_low_reg};
                     flash_page  <= addr_high_reg[5:1];
                     flash_prog  <= 1'b1;
                     op_cnt_reg  <= PROGRAM_UNITS;
                     state_reg   <= ST_PROG;
                  end
               end else if (tout_cnt_reg <= 16'd1) begin
                  write_reg <= 1'b0;
                  state_reg <= ST_IDLE;
               end else begin
                  tout_cnt_reg <= tout_cnt_reg - 16'd1;
               end
            end
            ST_PROG: begin
               if (flash_tick)
                  op_cnt_reg <= op_cnt_reg - 16'd1;
               if (flash_tick && op_cnt_reg <= 16'd1) begin
                  {addr_high_reg, addr_low_reg} <= {addr_high_reg, addr_low_reg} + 14'd1;
                  tout_cnt_reg <= TOUT;
                  state_reg    <= ST_WAIT;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
         if (pwr_wake) begin
            write_reg <= 1'b0;
            state_reg <= ST_IDLE;
         end
      end
   end

   // ***********************************************************
   // Interrupts: set wins over clear
   // ***********************************************************
   always @* begin
      irq_set = 3'b000;
      irq_set[`IRQ_ERASE_DONE] = (state_reg == ST_ERASE) && flash_tick && op_cnt_reg <= 16'd1;
      irq_set[`IRQ_WORD_DONE]  = (state_reg == ST_PROG) && flash_tick && op_cnt_reg <= 16'd1;
      irq_set[`IRQ_TIMEOUT]    = (state_reg == ST_WAIT) && !wr_dat && tout_cnt_reg <= 16'd1;
   end

   wire [2:0] irq_clr = (wr_hit && wr_idx == `IDX_IRQ_CLEAR) ? wb[2:0] : 3'b000;
   always @(posedge aclk) begin
      if (!aresetn)
         irq_status_reg <= 3'b000;
      else
         irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
   end
   assign irq = |(irq_status_reg & irq_enable_reg);

endmodule // flash_program_erase_control

// *** test/flash_program_erase_control_chk.sv ***
`timescale 1ns/100ps
module flash_program_erase_control_chk (
   input logic        aclk,
   input logic        aresetn,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready,
   input logic [31:0] s_axi_rdata,
   input logic        flash_prog,
   input logic        flash_erase,
   input logic        flash_tick
);
   // ****
   // Bus and flash timing
   // ****
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read response changed early");
   a_arready_low: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken during response");
   a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
      else $error("read response late");
   a_prog_pulse: assert property (flash_prog |=> !flash_prog)
      else $error("program start longer than one cycle");
   a_erase_pulse: assert property (flash_erase |=> !flash_erase)
      else $error("erase start longer than one cycle");
   a_erase_tick: assert property (flash_erase |-> ##[1:70] flash_tick)
      else $error("no timing tick during erase");
   a_prog_tick: assert property (flash_prog |-> ##[1:70] flash_tick)
      else $error("no timing tick during program");
endmodule // flash_program_erase_control_chk

bind flash_program_erase_control flash_program_erase_control_chk chk (.*);

// *** test/flash_array_model.sv ***
`timescale 1ns/100ps
module flash_array_model (
   input wire        aclk,
   input wire [13:0] flash_addr,
   input wire [15:0] flash_wdata,
   input wire        flash_prog,
   input wire        flash_erase,
   input wire [4:0]  flash_page
);
   // ****
   // Array: programming can only clear bits
   // ****
   reg [15:0] mem [0:16383];
   integer    i;
   always @(posedge aclk) begin
      if (flash_erase) begin
         for (i = 0; i < 512; i = i + 1) mem[{flash_page, i[8:0]}] <= 16'hFFFF;
      end
      if (flash_prog) mem[flash_addr] <= mem[flash_addr] & flash_wdata;
   end
endmodule // flash_array_model

// *** test/flash_program_erase_control_tb_top.sv ***
`timescale 1ns/100ps
module flash_program_erase_control_tb_top;
   // ****
   // Signals
   // ****
   reg        aclk, aresetn, s_axi_awvalid, s_axi_wvalid;
   reg        s_axi_bready, s_axi_arvalid, s_axi_rready;
   reg [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
   wire [3:0] s_axi_wstrb = 4'hF;
   wire       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire       flash_prog, flash_erase, flash_read_hold, flash_tick, irq;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [13:0] flash_addr;
   wire [15:0] flash_wdata;
   wire [4:0]  flash_page;
   integer     errors, checks_done, seed;
   reg [33:0]  q[$];
   reg [7:0]   i, lo, d0, d1;
   flash_program_erase_control #(.ERASE_UNITS(16'd4), .PROGRAM_UNITS(16'd2), .TIMEOUT_CYC(50))
      dut (.*);
   flash_array_model mdl (.*);
   always #12.5 aclk = ~aclk;
   // ****
   // Tasks
   // ****
   task summarize;
      begin
         if (errors == 0 && checks_done > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   task check(input [33:0] s, input [33:0] e);
      begin
         checks_done = checks_done + 1;
         if (s !== e) begin
            errors = errors + 1;
            $display("unexpected at %0t: seen %0h expected %0h", $time, s, e);
         end
      end
   endtask
   // One bus cycle; the expected response and data are queued for the watcher
   task xf(input r, input [7:0] a, input [7:0] d, input [33:0] e);
      integer n;
      reg     k;
      begin
         q.push_back(e);
         n = 0;
         if (r) begin
            s_axi_araddr <= {22'h0, a, 2'h0};
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
         end else begin
            s_axi_awaddr <= {22'h0, a, 2'h0};
            s_axi_wdata <= {24'h0, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
         end
         do begin
            @(posedge aclk);
            n = n + 1;
            if (r && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (!r && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (!r && s_axi_wready) s_axi_wvalid <= 1'b0;
            k = r ? s_axi_rvalid : s_axi_bvalid;
         end while (k !== 1'b1 && n < 99);
         s_axi_rready <= 1'b0;
         s_axi_bready <= 1'b0;
         @(posedge aclk);
         if (k !== 1'b1) begin
            errors = errors + 1;
            summarize;
         end
      end
   endtask
   task wait_irq;
      integer n;
      begin
         n = 0;
         while (irq !== 1'b1 && n < 2000) begin
            @(posedge aclk);
            n = n + 1;
         end
         if (n >= 2000) begin
            errors = errors + 1;
            summarize;
         end
      end
   endtask
   always @(posedge aclk) begin
      if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
         check(s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0}, q.pop_front());
      end
   end
   // ****
   // Main sequence
   // ****
   initial begin
      aclk = 0;
      aresetn = 0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      errors = 0;
      checks_done = 0;
      seed = 48;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      lo = $random(seed) & 8'h7E;
      d0 = $random(seed);
      d1 = $random(seed);
      for (i = 8'hAB; i < 8'hB0; i = i + 1) begin
         xf(1, i, 0, i == 8'hAB ? 34'h11 : 34'h0);
      end
      xf(1, 8'hB4, 0, 34'h200000000);
      xf(0, 8'hB4, 0, 34'h200000000);
      xf(0, 8'hAB, 8'h3F, 0);
      xf(1, 8'hAB, 0, 34'h3F);
      xf(0, 8'hAD, 8'h02, 0);
      xf(0, 8'hAC, lo, 0);
      xf(0, 8'hB1, 8'h07, 0);
      xf(0, 8'hAE, 8'h13, 0);
      xf(1, 8'hAE, 0, 34'h90);
      check({33'h0, flash_read_hold}, 34'h1);
      wait_irq;
      check({18'h0, mdl.mem[{6'h03, 8'hFF}]}, 34'hFFFF);
      xf(1, 8'hB0, 0, 34'h1);
      xf(0, 8'hB2, 8'h01, 0);
      xf(0, 8'hAF, d0, 0);
      xf(0, 8'hAF, d1, 0);
      xf(1, 8'hAE, 0, 34'hD0);
      wait_irq;
      check({18'h0, mdl.mem[{6'h02, lo}]}, {18'h0, d1, d0});
      xf(1, 8'hB0, 0, 34'h2);
      xf(0, 8'hB2, 8'h02, 0);
      wait_irq;
      xf(1, 8'hB0, 0, 34'h4);
      xf(0, 8'hB2, 8'h04, 0);
      xf(1, 8'hAE, 0, 34'h10);
      xf(1, 8'hAC, 0, {26'h0, lo + 8'h01});
      xf(0, 8'hAE, 8'h12, 0);
      xf(1, 8'hAE, 0, 34'h90);
      xf(0, 8'hB3, 8'h01, 0);
      xf(1, 8'hAE, 0, 34'h10);
      summarize;
   end
endmodule // flash_program_erase_control_tb_top
